// ==== design/sfcf_pkg.sv ====
// Constants, types and decode helpers of the serial flash command front end.
package sfcf_pkg;

  // Instruction codes recognised by the front end.
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_DDR_QUAD_IO_READ = 8'hed;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;

  // Field lengths in bits.
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
  localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] BYTE_BITS = 6'h08;

  // Upper nibble of the mode byte that keeps continuous read active.
  localparam logic [3:0] MODE_CONT_NIBBLE = 4'ha;

  // Bit positions inside the volatile status and configuration registers.
  localparam int STATUS_WIP_POS = 0;
  localparam int CFG1_QUAD_POS = 1;
  localparam int CFG2_FOUR_LANE_POS = 3;

  // Reset values.
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Phases of one command frame.
  typedef enum logic [2:0] {
    PH_INSTR, PH_ADDR, PH_MODE, PH_DUMMY, PH_WDATA, PH_RDATA, PH_TAIL, PH_IGNORE
  } sfcf_phase_t;

  // Properties of one decoded instruction.
  typedef struct packed {
    logic known;
    logic has_addr;
    logic has_mode;
    logic has_dummy;
    logic is_read;
    logic is_write;
    logic is_status;
    logic ddr;
    logic needs_quad;
    logic busy_ok;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
  } sfcf_cmd_t;

  // Maps an instruction to its frame layout; four-lane mode widens every phase.
  function automatic sfcf_cmd_t sfcf_decode(input logic [7:0] op, input logic four_lane);
    sfcf_cmd_t c;
    c = '0;
    c.known = 1'b1;
    c.addr_lanes = 3'h1;
    c.data_lanes = 3'h1;
    case (op)
      OP_READ: begin
        c.has_addr = 1'b1; c.is_read = 1'b1;
      end
      OP_FAST_READ: begin
        c.has_addr = 1'b1; c.has_dummy = 1'b1; c.is_read = 1'b1;
      end
      OP_DUAL_OUT_READ: begin
        c.has_addr = 1'b1; c.has_dummy = 1'b1; c.is_read = 1'b1; c.data_lanes = 3'h2;
      end
      OP_QUAD_OUT_READ: begin
        c.has_addr = 1'b1; c.has_dummy = 1'b1; c.is_read = 1'b1; c.data_lanes = 3'h4;
        c.needs_quad = 1'b1;
      end
      OP_DUAL_IO_READ: begin
        c.has_addr = 1'b1; c.has_mode = 1'b1; c.has_dummy = 1'b1; c.is_read = 1'b1;
        c.addr_lanes = 3'h2; c.data_lanes = 3'h2;
      end
      OP_QUAD_IO_READ, OP_DDR_QUAD_IO_READ: begin
        c.has_addr = 1'b1; c.has_mode = 1'b1; c.has_dummy = 1'b1; c.is_read = 1'b1;
        c.addr_lanes = 3'h4; c.data_lanes = 3'h4; c.needs_quad = 1'b1;
        c.ddr = (op == OP_DDR_QUAD_IO_READ);
      end
      OP_READ_STATUS: begin
        c.is_read = 1'b1; c.is_status = 1'b1; c.busy_ok = 1'b1;
      end
      OP_PROGRAM: begin
        c.has_addr = 1'b1; c.is_write = 1'b1;
      end
      OP_QUAD_PROGRAM: begin
        c.has_addr = 1'b1; c.is_write = 1'b1; c.data_lanes = 3'h4; c.needs_quad = 1'b1;
      end
      default: c.known = 1'b0;
    endcase
    if (four_lane) begin
      c.addr_lanes = 3'h4;
      c.data_lanes = 3'h4;
      c.needs_quad = 1'b0;
    end
    return c;
  endfunction

endpackage

// ==== design/sfcf_frontend.sv ====
// Command framing front end of a multi-lane serial flash, SCK side and core side.
`timescale 1ns/1ps

// What this block does
// - Sample inputs on SCK rising edges, launch outputs from falling edges; modes 0 and 3.
// - Cycles run falling edge to falling edge; mode 0 starts at chip-select fall.
// - DDR: instruction on rising edges only, address and data on both edges.
// - DDR: address starts at first rise after instruction; data at last dummy fall.
// - Each explicit command opens with an 8-bit instruction choosing later phases.
// - 1-1-1: everything in on IO0, read data out on IO1.
// - 1-1-2 and 1-1-4: serial address, dummies, then data on two or four lanes.
// - 1-2-2 and 1-4-4: address and data both on two or four lanes.
// - Four-lane command mode carries every phase as nibbles on IO0 to IO3.
// - In legacy mode the instruction fixes lane width of later phases.
// - IO0 holds the least significant bit of a group; groups go MSB first.
// - Address is 24 or 32 bits, one per rising edge or per edge in DDR.
// - Continuous read: the frame starts with the address, reusing the last read.
// - Mode bits after the address enter or leave continuous read.
// - Dummy cycles are clocked; first data driven on the last dummy falling edge.
// - Array reads keep streaming sequential bytes until chip select rises.
// - Non-read commands execute only when total bits are a multiple of eight.
// - Bits go MSB first; bytes go in rising address order.
// - While busy, array reads are ignored; only status read is accepted.
// - A status read returns the status byte including completion state.
// - With chip select high, inputs are ignored and lanes are released.
// - Write-in-progress status bit reads one while the core reports busy.
// - Quad enable opens lanes two and three; another bit selects four-lane mode.
// - Outside DDR, output data changes only after falling SCK edges.
module sfcf_frontend (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic busy,
  input wire logic [7:0] volatile_status_one,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic addr_long,
  input wire logic [3:0] dummy_cycles,
  input wire logic [7:0] rd_data,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [31:0] cmd_addr,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  output logic cmd_exec,
  output logic cmd_reject
);
  import sfcf_pkg::*;

  // Shifts a lane group into a register; IO0 lands in the least significant bit.
  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [3:0] io,
                                           input logic [2:0] lanes);
    logic [31:0] r;
    r = v;
    unique case (lanes)
      3'h1: r = {v[30:0], io[0]};
      3'h2: r = {v[29:0], io[1:0]};
      default: r = {v[27:0], io[3:0]};
    endcase
    return r;
  endfunction

  // Top group of a byte placed on the lanes; single lane answers on IO1.
  function automatic logic [3:0] out_group(input logic [7:0] b, input logic [2:0] lanes);
    logic [3:0] r;
    r = 4'h0;
    unique case (lanes)
      3'h1: r = {2'b00, b[7], 1'b0};
      3'h2: r = {2'b00, b[7:6]};
      default: r = b[7:4];
    endcase
    return r;
  endfunction

  // Lanes driven for a given data width.
  function automatic logic [3:0] out_mask(input logic [2:0] lanes);
    logic [3:0] r;
    r = 4'hf;
    if (lanes == 3'h1) r = 4'h2;
    else if (lanes == 3'h2) r = 4'h3;
    return r;
  endfunction

  // SCK side state that chip select clears.
  sfcf_phase_t phase_ff;
  logic [5:0] bits_ff;
  logic [3:0] dcnt_ff;
  logic first_ff;
  logic [31:0] sh_ff;
  logic [3:0] rise_ff;
  logic apend_ff;
  logic mpend_ff;
  logic ddr_in_ff;
  logic [31:0] sh_n_ff;
  logic [3:0] io_neg_ff;
  logic [3:0] io_pos_ff;
  logic [3:0] oe_ff;
  logic [7:0] out_sh_ff;
  logic [3:0] obits_ff;
  // SCK side state that outlives a frame.
  logic busy_m_ff;
  logic busy_s_ff;
  logic [7:0] op_ff;
  logic cont_ff;
  logic [7:0] cont_op_ff;
  logic [31:0] addr_s_ff;
  logic [7:0] wr_byte_s_ff;
  logic ins_tgl_ff;
  logic wr_tgl_ff;
  logic rd_tgl_ff;
  logic [2:0] algn_ff;
  logic accept_ff;
  logic read_ff;
  // Core side state.
  logic [2:0] cs_sync_ff;
  logic [2:0] ins_sync_ff;
  logic [2:0] wr_sync_ff;
  logic [2:0] rd_sync_ff;
  logic [7:0] rd_hold_ff;
  logic cmd_valid_ff;
  logic [7:0] cmd_opcode_ff;
  logic [31:0] cmd_addr_ff;
  logic wr_valid_ff;
  logic [7:0] wr_byte_ff;
  logic rd_req_ff;
  logic cmd_exec_ff;
  logic cmd_reject_ff;

  logic four_lane;
  logic quad_en;
  sfcf_phase_t eff_phase;
  logic [7:0] cur_op;
  sfcf_cmd_t dec;
  sfcf_cmd_t dn;
  logic [2:0] lanes;
  logic ddr_now;
  logic [3:0] step;
  logic [31:0] sh_next;
  logic [5:0] bits_sum;
  logic [5:0] ph_len;
  logic ph_done;
  logic [3:0] dummy_n;
  sfcf_phase_t post_phase;
  sfcf_phase_t instr_next;
  logic reject_n;
  logic [7:0] status_byte;
  logic [7:0] src_byte;
  logic load_now;
  logic [31:0] addr_src;

  // Lane selection and phase bookkeeping seen by the rising-edge logic.
  always_comb begin
    four_lane = volatile_config_two[CFG2_FOUR_LANE_POS];
    quad_en = volatile_config_one[CFG1_QUAD_POS];
    eff_phase = (phase_ff == PH_INSTR && cont_ff) ? PH_ADDR : phase_ff;
    cur_op = (phase_ff == PH_INSTR && cont_ff) ? cont_op_ff : op_ff;
    dec = sfcf_decode(cur_op, four_lane);
    unique case (eff_phase)
      PH_ADDR, PH_MODE: lanes = dec.addr_lanes;
      PH_WDATA: lanes = dec.data_lanes;
      default: lanes = four_lane ? 3'h4 : 3'h1;
    endcase
    ddr_now = dec.ddr && (eff_phase == PH_ADDR || eff_phase == PH_MODE);
    step = ddr_now ? {lanes, 1'b0} : {1'b0, lanes};
    sh_next = shift_in(sh_ff, io_in, lanes);
    bits_sum = bits_ff + {2'b00, step};
    unique case (eff_phase)
      PH_ADDR: ph_len = addr_long ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
      PH_MODE: ph_len = MODE_BITS;
      PH_WDATA: ph_len = BYTE_BITS;
      default: ph_len = INSTR_BITS;
    endcase
    ph_done = (bits_sum >= ph_len);
    dummy_n = dec.has_dummy ? dummy_cycles : 4'h0;
    if (dummy_n != 4'h0) post_phase = PH_DUMMY;
    else if (dec.is_read) post_phase = PH_RDATA;
    else if (dec.is_write) post_phase = PH_WDATA;
    else post_phase = PH_TAIL;
    dn = sfcf_decode(sh_next[7:0], four_lane);
    reject_n = !dn.known || (dn.needs_quad && !quad_en) || (busy_s_ff && !dn.busy_ok);
    if (reject_n) instr_next = PH_IGNORE;
    else if (dn.has_addr) instr_next = PH_ADDR;
    else if (dn.is_read) instr_next = PH_RDATA;
    else if (dn.is_write) instr_next = PH_WDATA;
    else instr_next = PH_TAIL;
    status_byte = volatile_status_one;
    status_byte[STATUS_WIP_POS] = busy_s_ff;
    src_byte = dec.is_status ? status_byte : rd_hold_ff;
    load_now = (phase_ff == PH_RDATA) && (obits_ff == 4'h0);
    addr_src = dec.ddr ? sh_n_ff : sh_ff;
  end

  // Busy level brought onto the SCK clock.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      busy_m_ff <= 1'b0;
      busy_s_ff <= 1'b0;
    end else begin
      busy_m_ff <= busy;
      busy_s_ff <= busy_m_ff;
    end
  end

  // Rising-edge framing; chip select high clears the partial command.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase_ff <= PH_INSTR;
      bits_ff <= 6'h00;
      dcnt_ff <= 4'h0;
      first_ff <= 1'b0;
      sh_ff <= ADDR_RESET;
      rise_ff <= 4'h0;
      apend_ff <= 1'b0;
      mpend_ff <= 1'b0;
      ddr_in_ff <= 1'b0;
    end else begin
      first_ff <= 1'b1;
      apend_ff <= 1'b0;
      mpend_ff <= 1'b0;
      rise_ff <= io_in;
      ddr_in_ff <= ddr_now;
      unique case (eff_phase)
        PH_INSTR: begin
          sh_ff <= sh_next;
          bits_ff <= bits_sum;
          if (ph_done) begin
            bits_ff <= 6'h00;
            phase_ff <= instr_next;
          end
        end
        PH_ADDR, PH_MODE: begin
          if (!ddr_now) sh_ff <= sh_next;
          bits_ff <= bits_sum;
          phase_ff <= PH_ADDR;
          if (busy_s_ff && !dec.busy_ok) begin
            phase_ff <= PH_IGNORE;
          end else if (ph_done) begin
            bits_ff <= 6'h00;
            if (eff_phase == PH_ADDR) begin
              apend_ff <= 1'b1;
              phase_ff <= dec.has_mode ? PH_MODE : post_phase;
            end else begin
              mpend_ff <= 1'b1;
              phase_ff <= post_phase;
            end
          end else begin
            phase_ff <= eff_phase;
          end
        end
        PH_DUMMY: begin
          dcnt_ff <= dcnt_ff + 4'h1;
          if (dcnt_ff + 4'h1 == dummy_n) phase_ff <= dec.is_read ? PH_RDATA : PH_TAIL;
        end
        PH_WDATA: begin
          sh_ff <= sh_next;
          bits_ff <= ph_done ? 6'h00 : bits_sum;
        end
        PH_RDATA, PH_TAIL, PH_IGNORE: begin
        end
      endcase
    end
  end

  // Rising-edge results that must stand after chip select rises.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      op_ff <= BYTE_RESET;
      cont_ff <= 1'b0;
      cont_op_ff <= BYTE_RESET;
      addr_s_ff <= ADDR_RESET;
      wr_byte_s_ff <= BYTE_RESET;
      ins_tgl_ff <= 1'b0;
      wr_tgl_ff <= 1'b0;
      algn_ff <= 3'h0;
      accept_ff <= 1'b0;
      read_ff <= 1'b0;
    end else if (!cs_n) begin
      algn_ff <= (first_ff ? algn_ff : 3'h0) + step[2:0];
      if (!first_ff) begin
        accept_ff <= 1'b0;
        read_ff <= 1'b0;
      end
      if (phase_ff == PH_INSTR && cont_ff) begin
        op_ff <= cont_op_ff;
        read_ff <= 1'b1;
      end else if (eff_phase == PH_INSTR && ph_done) begin
        op_ff <= sh_next[7:0];
        accept_ff <= !reject_n && !dn.is_read;
        read_ff <= !reject_n && dn.is_read;
        if (!reject_n && !dn.has_addr) begin
          addr_s_ff <= ADDR_RESET;
          ins_tgl_ff <= !ins_tgl_ff;
        end
      end
      // SDR addresses go out on the completing edge so the first byte is fetched in time.
      if (eff_phase == PH_ADDR && ph_done && !dec.ddr && !(busy_s_ff && !dec.busy_ok)) begin
        addr_s_ff <= addr_long ? sh_next : {8'h00, sh_next[23:0]};
        ins_tgl_ff <= !ins_tgl_ff;
      end
      if (apend_ff && dec.ddr) begin
        addr_s_ff <= addr_long ? addr_src : {8'h00, addr_src[23:0]};
        ins_tgl_ff <= !ins_tgl_ff;
      end
      if (mpend_ff) begin
        cont_ff <= (addr_src[7:4] == MODE_CONT_NIBBLE);
        cont_op_ff <= op_ff;
      end
      if (eff_phase == PH_WDATA && ph_done) begin
        wr_byte_s_ff <= sh_next[7:0];
        wr_tgl_ff <= !wr_tgl_ff;
      end
    end
  end

  // Falling-edge half of DDR input, and the output launcher.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      sh_n_ff <= ADDR_RESET;
      io_neg_ff <= 4'h0;
      oe_ff <= 4'h0;
      out_sh_ff <= BYTE_RESET;
      obits_ff <= 4'h0;
    end else begin
      if (ddr_in_ff) sh_n_ff <= {sh_n_ff[23:0], rise_ff, io_in};
      if (load_now) begin
        io_neg_ff <= out_group(src_byte, dec.data_lanes);
        oe_ff <= out_mask(dec.data_lanes);
        out_sh_ff <= dec.ddr ? src_byte : (src_byte << dec.data_lanes);
        obits_ff <= dec.ddr ? 4'h0 : (4'h8 - {1'b0, dec.data_lanes});
      end else if (phase_ff == PH_RDATA) begin
        io_neg_ff <= out_group(out_sh_ff, dec.data_lanes);
        out_sh_ff <= out_sh_ff << dec.data_lanes;
        obits_ff <= obits_ff - {1'b0, dec.data_lanes};
      end
    end
  end

  // Each array byte taken for output asks the core for the next one.
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      rd_tgl_ff <= 1'b0;
    end else if (!cs_n && load_now && !dec.is_status) begin
      rd_tgl_ff <= !rd_tgl_ff;
    end
  end

  // Second nibble of a DDR byte, launched on the rising edge.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) io_pos_ff <= 4'h0;
    else io_pos_ff <= out_sh_ff[3:0];
  end

  // In DDR reads the lanes follow the half of the cycle that is running.
  assign io_out = (dec.ddr && sck) ? io_pos_ff : io_neg_ff;
  assign io_oe = oe_ff;

  // Core side: synchronisers and event pulses.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_sync_ff <= 3'h7;
      ins_sync_ff <= 3'h0;
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
      rd_hold_ff <= BYTE_RESET;
      cmd_valid_ff <= 1'b0;
      cmd_opcode_ff <= BYTE_RESET;
      cmd_addr_ff <= ADDR_RESET;
      wr_valid_ff <= 1'b0;
      wr_byte_ff <= BYTE_RESET;
      rd_req_ff <= 1'b0;
      cmd_exec_ff <= 1'b0;
      cmd_reject_ff <= 1'b0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
      ins_sync_ff <= {ins_sync_ff[1:0], ins_tgl_ff};
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
      cmd_valid_ff <= ins_sync_ff[2] ^ ins_sync_ff[1];
      if (ins_sync_ff[2] ^ ins_sync_ff[1]) begin
        cmd_opcode_ff <= op_ff;
        cmd_addr_ff <= addr_s_ff;
      end
      wr_valid_ff <= wr_sync_ff[2] ^ wr_sync_ff[1];
      if (wr_sync_ff[2] ^ wr_sync_ff[1]) wr_byte_ff <= wr_byte_s_ff;
      rd_req_ff <= rd_sync_ff[2] ^ rd_sync_ff[1];
      if (cmd_valid_ff || rd_req_ff) rd_hold_ff <= rd_data;
      cmd_exec_ff <= 1'b0;
      cmd_reject_ff <= 1'b0;
      if (cs_sync_ff[1] && !cs_sync_ff[2]) begin
        cmd_exec_ff <= accept_ff && (algn_ff == 3'h0);
        cmd_reject_ff <= !read_ff && !(accept_ff && (algn_ff == 3'h0));
      end
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd_opcode = cmd_opcode_ff;
  assign cmd_addr = cmd_addr_ff;
  assign wr_valid = wr_valid_ff;
  assign wr_byte = wr_byte_ff;
  assign rd_req = rd_req_ff;
  assign cmd_exec = cmd_exec_ff;
  assign cmd_reject = cmd_reject_ff;

endmodule // sfcf_frontend

// ==== bench/sfcf_frontend_sva.sv ====
// Concurrent checks on the ports of the command front end.
`timescale 1ns/1ps
module sfcf_frontend_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input wire logic busy,
  input wire logic [7:0] volatile_config_one,
  input wire logic [7:0] volatile_config_two,
  input wire logic addr_long,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_addr,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic cmd_exec,
  input wire logic cmd_reject
);
  // Every check runs on the core clock and rests during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_idle_lanes_off: assert property (cs_n |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_stands: assert property ((io_oe != 4'h0) && !cs_n ##1 !cs_n |-> $stable(io_oe))
    else $error("lane enables moved inside a frame");
  a_lane_sets: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("lane enable pattern not a legal width");
  a_quad_gate: assert property (|io_oe[3:2] |-> volatile_config_one[1] || volatile_config_two[3])
    else $error("upper lanes driven with quad off");
  a_end_after_cs: assert property (cmd_exec || cmd_reject |-> cs_n && $past(cs_n, 2))
    else $error("frame verdict before deselect");
  a_end_exclusive: assert property (!(cmd_exec && cmd_reject))
    else $error("frame both executed and rejected");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command event longer than one cycle");
  a_short_addr: assert property (cmd_valid && !addr_long |-> cmd_addr[31:24] == 8'h00)
    else $error("short address has upper byte set");
  a_busy_no_read: assert property (busy && $past(busy, 8) |-> !rd_req)
    else $error("array byte consumed while busy");
  a_idle_quiet: assert property (cs_n && $past(cs_n, 6) |-> !(cmd_valid || wr_valid || rd_req))
    else $error("core event while deselected");
  c_exec: cover property (cmd_exec);
  c_reject: cover property (cmd_reject);
  c_stream: cover property (rd_req ##[1:40] rd_req);
endmodule // sfcf_frontend_sva

bind sfcf_frontend sfcf_frontend_sva u_sva (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .io_oe(io_oe), .busy(busy), .volatile_config_one(volatile_config_one),
  .volatile_config_two(volatile_config_two), .addr_long(addr_long), .cmd_valid(cmd_valid),
  .cmd_addr(cmd_addr), .wr_valid(wr_valid), .rd_req(rd_req), .cmd_exec(cmd_exec),
  .cmd_reject(cmd_reject));

// ==== bench/sfcf_host_model.sv ====
// Behavioural host bus master driving the flash lanes in clock mode 0.
`timescale 1ns/1ps
module sfcf_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_wire,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] h_out = 4'h0;
  logic [3:0] h_oe = 4'h0;
  logic [3:0] smp = 4'h0;
  int nbits = 0;

  // Lane level: device first, then host, else pull-ups on 2-3 and a toggling float on 0-1.
  assign io_wire = (io_oe & io_out) | (~io_oe & h_oe & h_out) | (~io_oe & ~h_oe & {2'b11, sck, ~sck});

  // The clock idles low; a deselect edge at the start clears the frame state.
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end

  // One cycle: the rise samples, an optional stretch lets the core catch up, the fall ends it.
  task automatic tick(input bit gap);
    #3 sck = 1'b1;
    smp = io_wire;
    if (gap) #250;
    #3 sck = 1'b0;
  endtask

  // Selects the device for a new frame.
  task automatic frame_on();
    nbits = 0;
    #50 cs_n = 1'b0;
    #10;
  endtask

  // Shifts a value out most significant group first, lane zero holding the low bit.
  task automatic send(input logic [31:0] v, input int nb, input int ln);
    for (int i = nb; i > 0; i -= ln) begin
      h_oe = (ln == 4) ? 4'hf : (ln == 2) ? 4'h3 : 4'h1;
      h_out = 4'(v >> (i - ln)) & h_oe;
      nbits += ln;
      tick(nbits % 8 == 0);
    end
  endtask

  // Keeps the clock running through latency cycles with the lanes released.
  task automatic idle(input int n);
    h_oe = 4'h0;
    for (int i = 1; i <= n; i++) tick(i == n);
  endtask

  // Collects one byte; a single lane reads the serial output line.
  task automatic recv(output logic [7:0] b, input int ln);
    h_oe = 4'h0;
    b = 8'h00;
    for (int i = ln; i <= 8; i += ln) begin
      tick(i == 8);
      b = (b << ln) | ((ln == 1) ? 8'(smp[1]) : (ln == 2) ? 8'(smp[1:0]) : 8'(smp));
    end
  endtask

  // Ends the frame after the last falling edge.
  task automatic frame_off();
    #3 cs_n = 1'b1;
    h_oe = 4'h0;
    #300;
  endtask
endmodule // sfcf_host_model

// ==== bench/sfcf_frontend_tb_top.sv ====
// Self-checking bench for the command front end with a host model and a core model.
`timescale 1ns/1ps
module sfcf_frontend_tb_top;
  import sfcf_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic busy = 1'b0;
  logic addr_long = 1'b0;
  logic sck, cs_n, cmd_valid, wr_valid, rd_req, cmd_exec, cmd_reject;
  logic [3:0] io_in, io_out, io_oe;
  logic [3:0] dummy_cycles = 4'h0;
  logic [7:0] rd_data = 8'h00, stat = 8'h00, cfg1 = 8'h00, cfg2 = 8'h00, ofs = 8'h00;
  logic [7:0] rx, cmd_opcode, wr_byte, got_op;
  logic [31:0] cmd_addr, got_addr;
  logic [7:0] wq[$];
  int mismatches = 0, checked = 0, n_exec = 0, n_rej = 0;

  // Core clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;

  sfcf_frontend u_dut (.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .busy(busy), .volatile_status_one(stat),
    .volatile_config_one(cfg1), .volatile_config_two(cfg2), .addr_long(addr_long),
    .dummy_cycles(dummy_cycles), .rd_data(rd_data), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .wr_valid(wr_valid), .wr_byte(wr_byte),
    .rd_req(rd_req), .cmd_exec(cmd_exec), .cmd_reject(cmd_reject));
  sfcf_host_model u_host (.sck(sck), .cs_n(cs_n), .io_wire(io_in), .io_out(io_out),
    .io_oe(io_oe));

  // Array contents seen by the front end.
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h3c;
  endfunction

  // Core model: hands out sequential array bytes and records every core event.
  always @(negedge core_clk) begin
    if (cmd_valid) got_op = cmd_opcode;
    if (cmd_valid) got_addr = cmd_addr;
    if (cmd_valid) ofs = 8'h00;
    if (rd_req) ofs = ofs + 8'h01;
    if (wr_valid) wq.push_back(wr_byte);
    if (cmd_exec) n_exec++;
    if (cmd_reject) n_rej++;
    rd_data <= pat(cmd_addr[7:0] + ofs);
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Program frame with two data bytes, optionally cut a few bits past a byte.
  task automatic prog(input logic [7:0] op, input int ol, input int al, input int dl, input int tail);
    u_host.frame_on();
    u_host.send(32'(op), 8, ol);
    u_host.send(32'h000123, 24, al);
    u_host.send(32'ha5, 8, dl);
    u_host.send(32'h3c, 8, dl);
    if (tail > 0) u_host.send(32'h5, tail, 1);
    u_host.frame_off();
    chk(got_op, op);
    chk(got_addr, 32'h000123);
    chk(wq.pop_front(), 8'ha5);
    chk(wq.pop_front(), 8'h3c);
  endtask

  // Read frame; an opcode of zero means the frame starts with the address.
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab, input int al,
    input int md, input int dm, input int dl);
    u_host.frame_on();
    if (op != 8'h00) u_host.send(32'(op), 8, 1);
    u_host.send(a, ab, al);
    if (md >= 0) u_host.send(32'(md), 8, al);
    u_host.idle(dm);
    for (int i = 0; i < 3; i++) begin
      u_host.recv(rx, dl);
      chk(rx, pat(a[7:0] + 8'(i)));
    end
    u_host.frame_off();
    chk(got_addr, a);
  endtask

  // Status read compared against the expected status byte.
  task automatic status(input logic [7:0] exp);
    u_host.frame_on();
    u_host.send(32'(OP_READ_STATUS), 8, 1);
    u_host.recv(rx, 1);
    u_host.frame_off();
    chk(rx, exp);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    #1 rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    prog(OP_PROGRAM, 1, 1, 1, 0);
    chk(n_exec, 1);
    prog(OP_PROGRAM, 1, 1, 1, 3);
    chk(n_rej, 1);
    $display("test program done");
    rd(OP_READ, 32'h0000fe, 24, 1, -1, 0, 1);
    dummy_cycles = 4'h8;
    addr_long = 1'b1;
    rd(OP_DUAL_OUT_READ, 32'h0100_0040, 32, 1, -1, 8, 2);
    addr_long = 1'b0;
    dummy_cycles = 4'h4;
    cfg1 = 8'h02;
    rd(OP_QUAD_IO_READ, 32'h000210, 24, 4, 8'ha0, 4, 4);
    rd(8'h00, 32'h000330, 24, 4, 8'h00, 4, 4);
    chk(got_op, OP_QUAD_IO_READ);
    rd(OP_DUAL_IO_READ, 32'h000450, 24, 2, 8'h00, 4, 2);
    rd(OP_FAST_READ, 32'h000520, 24, 1, -1, 4, 1);
    $display("test reads done");
    prog(OP_QUAD_PROGRAM, 1, 1, 4, 0);
    cfg1 = 8'h00;
    cfg2 = 8'h08;
    prog(OP_PROGRAM, 4, 4, 4, 0);
    chk(n_exec, 3);
    cfg2 = 8'h00;
    $display("test lanes done");
    busy = 1'b1;
    stat = 8'h5c;
    status(8'h5d);
    u_host.frame_on();
    u_host.send(32'(OP_READ), 8, 1);
    u_host.send(32'h000040, 24, 1);
    u_host.recv(rx, 1);
    u_host.frame_off();
    chk(n_rej, 2);
    busy = 1'b0;
    status(8'h5c);
    u_host.frame_on();
    u_host.send(32'(OP_QUAD_OUT_READ), 8, 1);
    u_host.send(32'h000040, 24, 1);
    u_host.frame_off();
    chk(n_rej, 3);
    $display("test busy done");
    tally_and_finish();
  end
endmodule // sfcf_frontend_tb_top
